// File: hw/lpgd_pkg.sv
// Shared constants and types of the LED PWM group dimmer.
package lpgd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int NUM_CH = 16;
    localparam int PWM_BITS = 8;
    localparam int PWM_STEPS = 256;
    localparam int SYS_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Group stage timing: one group step lasts a fixed or programmable number of clocks.
    localparam int GRP_DIM_HZ = 190;
    localparam int GRP_DIM_STEP_CYC = 1000000000 / (GRP_DIM_HZ * SYS_PERIOD_NS * PWM_STEPS);
    localparam int BLINK_MAX_HZ = 24;
    localparam int BLINK_STEP_CYC = 1000000000 / (BLINK_MAX_HZ * SYS_PERIOD_NS * PWM_STEPS);
    localparam int PRE_BITS = 21;

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end timing, counted on the link clock.
    localparam int SPIKE_NS = 50;
    localparam int FILT_CYC = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYC = (TIMEOUT_MS * 1000000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Fault flag packing and reset values.
    localparam int FLAG_LOW_LSB = 0;
    localparam int FLAG_HIGH_LSB = 8;
    localparam logic [15:0] LED_RST = 16'h0000;
    localparam logic [15:0] FLAG_RST = 16'h0000;
    localparam logic [7:0] CNT_RST = 8'h00;

    typedef enum logic [1:0] {
        LPGD_OFF = 2'b00,
        LPGD_ON = 2'b01,
        LPGD_PWM = 2'b10,
        LPGD_GRP = 2'b11
    } lpgd_chmode_t;

endpackage

// File: hw/lpgd_link_if.sv
// Filtered bus line levels and time-out event handed from the link domain to the core.
interface lpgd_link_if;
    logic scl_filt;
    logic sda_filt;
    logic timeout_tgl;

    modport front (output scl_filt, output sda_filt, output timeout_tgl);
    modport core (input scl_filt, input sda_filt, input timeout_tgl);
endinterface

// File: hw/lpgd_link_front.sv
// Bus line spike filter and stuck-low time-out, running on the link clock.
module lpgd_link_front #(
    parameter int TIMEOUT_CYC = lpgd_pkg::TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic link_clk,
    input wire logic srst,
    // Bus pins and control
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic timeout_en,
    // Towards the core
    lpgd_link_if.front lnk
);

    if (TIMEOUT_CYC <= lpgd_pkg::FILT_CYC) begin : g_chk
        $error("TIMEOUT_CYC too small");
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_s;
    logic [2:0] scl_s, sda_s, en_s;
    logic scl_f_r, sda_f_r, en_r, tgl_r, fired_r;
    logic [1:0] scl_st_r, sda_st_r;
    logic [31:0] to_cnt_r;
    logic rst;

    assign rst = rst_s[1];

    // The reset synchroniser carries no reset of its own.
    always_ff @(posedge link_clk) begin
        rst_s <= {rst_s[0], srst};
    end

    always_ff @(posedge link_clk) begin
        scl_s <= {scl_s[1:0], scl_in};
        sda_s <= {sda_s[1:0], sda_in};
        en_s <= {en_s[1:0], timeout_en};
    end

    ////////////////////////////////////////////////////////////////////////////
    // A new level is taken only after it has stood FILT_CYC + 1 link cycles.
    wire scl_new = (scl_s[1] == scl_s[2]) && (scl_s[2] != scl_f_r);
    wire sda_new = (sda_s[1] == sda_s[2]) && (sda_s[2] != sda_f_r);
    wire scl_take = scl_new && (scl_st_r == 2'(lpgd_pkg::FILT_CYC - 1));
    wire sda_take = sda_new && (sda_st_r == 2'(lpgd_pkg::FILT_CYC - 1));
    wire line_low = !scl_f_r || !sda_f_r;
    wire to_hit = en_r && line_low && !fired_r && (to_cnt_r == 32'(TIMEOUT_CYC - 1));

    always_ff @(posedge link_clk) begin
        if (rst) begin
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_st_r <= 2'b00;
            sda_st_r <= 2'b00;
            en_r <= 1'b0;
        end else begin
            scl_st_r <= scl_new && !scl_take ? scl_st_r + 2'b01 : 2'b00;
            sda_st_r <= sda_new && !sda_take ? sda_st_r + 2'b01 : 2'b00;
            if (scl_take) scl_f_r <= scl_s[2];
            if (sda_take) sda_f_r <= sda_s[2];
            if (en_s[1] == en_s[2]) en_r <= en_s[2];
        end
    end

    // One event per low stretch; disabled for static clock operation.
    always_ff @(posedge link_clk) begin
        if (rst) begin
            to_cnt_r <= 32'h0;
            fired_r <= 1'b0;
            tgl_r <= 1'b0;
        end else begin
            to_cnt_r <= (en_r && line_low && !fired_r && !to_hit) ? to_cnt_r + 32'h1 : 32'h0;
            fired_r <= line_low && (fired_r || to_hit);
            if (to_hit) tgl_r <= !tgl_r;
        end
    end

    assign lnk.scl_filt = scl_f_r;
    assign lnk.sda_filt = sda_f_r;
    assign lnk.timeout_tgl = tgl_r;

    ////////////////////////////////////////////////////////////////////////////
    a_timeout_fire: assert property (@(posedge link_clk) disable iff (rst)
        $changed(tgl_r) |-> $past(to_cnt_r) == 32'(TIMEOUT_CYC - 1) && $past(en_r))
        else $error("time-out fired at wrong count");
    a_timeout_off: assert property (@(posedge link_clk) disable iff (rst)
        !en_r |=> $stable(tgl_r))
        else $error("time-out fired while disabled");
    a_spike_filter: assert property (@(posedge link_clk) disable iff (rst)
        $changed(scl_f_r) |-> $past(scl_s[2], 1) == $past(scl_s[2], 2))
        else $error("short pulse passed the filter");
    c_timeout: cover property (@(posedge link_clk) disable iff (rst) $changed(tgl_r));

endmodule // lpgd_link_front

// File: hw/lpgd_top.sv
// Per-channel LED PWM with shared group dimming or blinking and open-load flags.

module lpgd_top #(
    parameter int NUM_CH = lpgd_pkg::NUM_CH,
    parameter int TIMEOUT_CYC = lpgd_pkg::TIMEOUT_CYC
) (
    // Clocks and reset
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic LINK_CLK,
    // Channel settings
    input wire logic [2*NUM_CH-1:0] CH_MODE,
    input wire logic [8*NUM_CH-1:0] CH_DUTY,
    // Group stage settings
    input wire logic GRP_BLINK,
    input wire logic [7:0] GRP_DUTY,
    input wire logic [7:0] GRP_PERIOD,
    // Current sense comparators, high when current meets the threshold
    input wire logic [NUM_CH-1:0] OPEN_LOAD_THRESHOLD_CURRENT_OK,
    // Serial bus lines
    input wire logic BUS_SCL,
    input wire logic BUS_SDA,
    input wire logic BUS_TIMEOUT_EN,
    // Outputs
    output logic [NUM_CH-1:0] LED_ON,
    output logic [7:0] CHANNEL_FAULT_FLAGS_LOW,
    output logic [7:0] CHANNEL_FAULT_FLAGS_HIGH,
    output logic BUS_SCL_LVL,
    output logic BUS_SDA_LVL,
    output logic BUS_IF_RESET
);

    if (NUM_CH != 16) begin : g_chk
        $error("NUM_CH must be 16 for the two flag registers");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel output: off, full on, PWM alone, or PWM gated by the group stage.
    function automatic logic ch_out(input logic [1:0] mode, input logic [7:0] cnt,
                                    input logic [7:0] duty, input logic grp);
        logic pwm;
        pwm = cnt < duty;
        case (mode)
            lpgd_pkg::LPGD_OFF: ch_out = 1'b0;
            lpgd_pkg::LPGD_ON: ch_out = 1'b1;
            lpgd_pkg::LPGD_PWM: ch_out = pwm;
            lpgd_pkg::LPGD_GRP: ch_out = pwm && grp;
            default: ch_out = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] pwm_cnt_r;
    logic [7:0] grp_cnt_r;
    logic [lpgd_pkg::PRE_BITS-1:0] pre_cnt_r;
    logic grp_on_r;
    logic [NUM_CH-1:0] led_r;
    logic [NUM_CH-1:0] flags_r;
    logic [NUM_CH-1:0] sense_s1, sense_s2, sense_s3, sense_r;
    logic [2:0] x_s1, x_s2, x_s3, x_r;
    logic bus_rst_r;

    lpgd_link_if lnk ();

    lpgd_link_front #(
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_front (
        .link_clk(LINK_CLK),
        .srst(SRST),
        .scl_in(BUS_SCL),
        .sda_in(BUS_SDA),
        .timeout_en(BUS_TIMEOUT_EN),
        .lnk(lnk.front)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Group step length: fixed in dimming use, (period + 1) base steps in blinking use.
    wire [lpgd_pkg::PRE_BITS-1:0] step_len = GRP_BLINK ?
        lpgd_pkg::PRE_BITS'((22'(GRP_PERIOD) + 22'h1) * 22'(lpgd_pkg::BLINK_STEP_CYC)) :
        lpgd_pkg::PRE_BITS'(lpgd_pkg::GRP_DIM_STEP_CYC);
    wire pre_wrap = pre_cnt_r >= step_len - lpgd_pkg::PRE_BITS'(1);
    wire grp_nxt = grp_cnt_r < GRP_DUTY;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pwm_cnt_r <= lpgd_pkg::CNT_RST;
            grp_cnt_r <= lpgd_pkg::CNT_RST;
            pre_cnt_r <= '0;
            grp_on_r <= 1'b0;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 8'h01;
            pre_cnt_r <= pre_wrap ? '0 : pre_cnt_r + lpgd_pkg::PRE_BITS'(1);
            if (pre_wrap) grp_cnt_r <= grp_cnt_r + 8'h01;
            grp_on_r <= grp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sense inputs come from the analog side; a change counts when stages two and three agree.
    // The stages are cleared to idle levels so that a short reset leaves no unknown behind.
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sense_s1 <= '0;
            sense_s2 <= '0;
            sense_s3 <= '0;
            x_s1 <= 3'b011;
            x_s2 <= 3'b011;
            x_s3 <= 3'b011;
        end else begin
            sense_s1 <= OPEN_LOAD_THRESHOLD_CURRENT_OK;
            sense_s2 <= sense_s1;
            sense_s3 <= sense_s2;
            x_s1 <= {lnk.timeout_tgl, lnk.sda_filt, lnk.scl_filt};
            x_s2 <= x_s1;
            x_s3 <= x_s2;
        end
    end

    wire [NUM_CH-1:0] sense_agree = ~(sense_s2 ^ sense_s3);
    wire [NUM_CH-1:0] sense_nxt = (sense_agree & sense_s3) | (~sense_agree & sense_r);
    wire [2:0] x_agree = ~(x_s2 ^ x_s3);
    wire [2:0] x_nxt = (x_agree & x_s3) | (~x_agree & x_r);

    logic [NUM_CH-1:0] led_nxt;
    logic [NUM_CH-1:0] flags_nxt;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            led_nxt[i] = ch_out(CH_MODE[2*i +: 2], pwm_cnt_r, CH_DUTY[8*i +: 8], grp_on_r);
            case (CH_MODE[2*i +: 2])
                lpgd_pkg::LPGD_OFF: flags_nxt[i] = 1'b0;
                lpgd_pkg::LPGD_ON: flags_nxt[i] = sense_r[i];
                default: flags_nxt[i] = flags_r[i];
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sense_r <= '0;
            x_r <= 3'b011;
            led_r <= lpgd_pkg::LED_RST;
            flags_r <= lpgd_pkg::FLAG_RST;
            bus_rst_r <= 1'b0;
        end else begin
            sense_r <= sense_nxt;
            x_r <= x_nxt;
            led_r <= led_nxt;
            flags_r <= flags_nxt;
            bus_rst_r <= x_nxt[2] != x_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign LED_ON = led_r;
    assign CHANNEL_FAULT_FLAGS_LOW = flags_r[lpgd_pkg::FLAG_LOW_LSB +: 8];
    assign CHANNEL_FAULT_FLAGS_HIGH = flags_r[lpgd_pkg::FLAG_HIGH_LSB +: 8];
    assign BUS_SCL_LVL = x_r[0];
    assign BUS_SDA_LVL = x_r[1];
    assign BUS_IF_RESET = bus_rst_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the channel, group, flag and bus reset logic, all sampled on the system clock.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    a_pwm_wrap: assert property (
        pwm_cnt_r == 8'hff |=> pwm_cnt_r == 8'h00 ##1 pwm_cnt_r == 8'h01)
        else $error("channel PWM counter does not wrap after 256 steps");
    a_pwm_duty: assert property (
        CH_MODE[1:0] == lpgd_pkg::LPGD_PWM |=> LED_ON[0] == ($past(pwm_cnt_r) < $past(CH_DUTY[7:0])))
        else $error("channel 0 PWM level wrong");
    a_dim_step: assert property (
        !GRP_BLINK && pre_cnt_r == '0 ##1 !GRP_BLINK [*8] |-> $stable(grp_cnt_r))
        else $error("group counter stepped too early in dimming use");
    a_blink_len: assert property (
        pre_wrap && GRP_BLINK && $stable(GRP_PERIOD) && $stable(GRP_BLINK) |->
        pre_cnt_r >= lpgd_pkg::PRE_BITS'((22'(GRP_PERIOD) + 22'h1) * 22'h0fe5) - 21'h1)
        else $error("blink step length wrong");
    a_grp_common: assert property (
        !$past(SRST) |-> grp_on_r == $past(grp_cnt_r < GRP_DUTY))
        else $error("group level does not follow group duty");
    a_grp_gates: assert property (
        CH_MODE[1:0] == lpgd_pkg::LPGD_GRP |=>
        LED_ON[0] == ($past(pwm_cnt_r) < $past(CH_DUTY[7:0]) && $past(grp_on_r)))
        else $error("group stage does not gate channel PWM");
    a_open_flag: assert property (
        CH_MODE[1:0] == lpgd_pkg::LPGD_ON |=> CHANNEL_FAULT_FLAGS_LOW[0] == $past(sense_r[0]))
        else $error("open-load flag wrong for full-on channel");
    a_flag_hold: assert property (
        CH_MODE[17:16] inside {lpgd_pkg::LPGD_PWM, lpgd_pkg::LPGD_GRP} |=>
        $stable(CHANNEL_FAULT_FLAGS_HIGH[0]))
        else $error("open-load flag changed while channel modulated");
    a_flag_on_ok: assert property (
        CH_MODE[1:0] == lpgd_pkg::LPGD_ON && sense_r[0] |=> CHANNEL_FAULT_FLAGS_LOW[0])
        else $error("good current not shown as 1");
    a_bus_reset: assert property (
        BUS_IF_RESET |=> !BUS_IF_RESET)
        else $error("bus reset pulse longer than one cycle");
    a_pwm_full: assert property (
        CH_MODE[1:0] == lpgd_pkg::LPGD_PWM && pwm_cnt_r == 8'hff |=> !LED_ON[0])
        else $error("channel PWM reached full on");
    a_flag_off: assert property (
        CH_MODE[1:0] == lpgd_pkg::LPGD_OFF |=> !CHANNEL_FAULT_FLAGS_LOW[0])
        else $error("open-load flag set for an off channel");

    c_blink: cover property (GRP_BLINK && pre_wrap && grp_cnt_r == 8'hff);
    c_open: cover property (CH_MODE[1:0] == lpgd_pkg::LPGD_ON ##1 !CHANNEL_FAULT_FLAGS_LOW[0]);
    c_grp: cover property (CH_MODE[1:0] == lpgd_pkg::LPGD_GRP && LED_ON[0]);
    c_dim_step: cover property (!GRP_BLINK && pre_wrap);

endmodule // lpgd_top

// File: tb/lpgd_bus_host.sv
// Behavioural bus host that drives the two pulled-up serial bus lines.
module lpgd_bus_host (
    // Link clock
    input wire logic link_clk,
    // Bus lines
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Pulls one line low for n link cycles, then releases it to the pull-up level.
    task automatic pulse(input int line, input int n);
        @(posedge link_clk);
        if (line == 0) scl <= 1'b0;
        else sda <= 1'b0;
        repeat (n) @(posedge link_clk);
        scl <= 1'b1;
        sda <= 1'b1;
    endtask
endmodule // lpgd_bus_host

// File: tb/tb.sv
// Self-checking testbench of the LED PWM group dimmer.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TO_CYC = 20;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] ch_mode = '0;
    logic [127:0] ch_duty = '0;
    logic grp_blink = 1'b0;
    logic [7:0] grp_duty = 8'h00;
    logic [7:0] grp_period = 8'h00;
    logic [15:0] cur_ok = 16'h0000;
    logic to_en = 1'b0;
    wire scl;
    wire sda;
    wire [15:0] led_on;
    wire [7:0] fl_lo;
    wire [7:0] fl_hi;
    wire scl_lvl;
    wire sda_lvl;
    wire if_rst;
    int fail_count = 0;
    int n_tests = 0;
    int cnt [4];
    logic [11:0] others;
    logic [1:0] low_seen;
    int rst_pulses;

    always #20 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end

    lpgd_top #(.TIMEOUT_CYC(TO_CYC)) DUT (
        .SYS_CLK(sys_clk), .SRST(srst), .LINK_CLK(link_clk),
        .CH_MODE(ch_mode), .CH_DUTY(ch_duty), .GRP_BLINK(grp_blink),
        .GRP_DUTY(grp_duty), .GRP_PERIOD(grp_period),
        .OPEN_LOAD_THRESHOLD_CURRENT_OK(cur_ok), .BUS_SCL(scl), .BUS_SDA(sda),
        .BUS_TIMEOUT_EN(to_en), .LED_ON(led_on), .CHANNEL_FAULT_FLAGS_LOW(fl_lo),
        .CHANNEL_FAULT_FLAGS_HIGH(fl_hi), .BUS_SCL_LVL(scl_lvl), .BUS_SDA_LVL(sda_lvl),
        .BUS_IF_RESET(if_rst)
    );

    lpgd_bus_host HOST (.link_clk(link_clk), .scl(scl), .sda(sda));

    // Watches filtered levels and time-out pulses on every settled sample.
    always @(negedge sys_clk) begin
        if (scl_lvl !== 1'b1) low_seen[0] <= 1'b1;
        if (sda_lvl !== 1'b1) low_seen[1] <= 1'b1;
        if (if_rst === 1'b1) rst_pulses <= rst_pulses + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Counts high samples of channels 0 to 3 over one full 256-cycle period.
    task automatic measure;
        cnt = '{0, 0, 0, 0};
        others = '0;
        for (int k = 0; k < 256; k++) begin
            cyc(1);
            for (int i = 0; i < 4; i++) cnt[i] += int'(led_on[i]);
            others |= led_on[15:4];
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        cyc(2);
        check("reset outputs", {led_on[11:0], if_rst, scl_lvl, sda_lvl, 1'b0}, 16'h0006);
        check("reset flags", {fl_hi, fl_lo}, 16'h0000);
        srst = 1'b0;
    endtask

    task automatic t_pwm;
        ch_mode = 32'h0000_006a;
        ch_duty = {96'h0, 8'h00, 8'hff, 8'h40, 8'h00};
        cyc(4);
        measure();
        check("pwm duty 00", 16'(cnt[0]), 16'd0);
        check("pwm duty 40", 16'(cnt[1]), 16'd64);
        check("pwm duty ff", 16'(cnt[2]), 16'd255);
        check("full on", 16'(cnt[3]), 16'd256);
        check("off channels", {4'h0, others}, 16'h0000);
    endtask

    task automatic t_group;
        ch_mode = 32'h0000_000f;
        ch_duty = {112'h0, 8'h80, 8'h40};
        for (int b = 0; b < 2; b++) begin
            grp_blink = b[0];
            grp_duty = 8'h00;
            cyc(4);
            measure();
            check("group duty 00 ch0", 16'(cnt[0]), 16'd0);
            check("group duty 00 ch1", 16'(cnt[1]), 16'd0);
            grp_duty = 8'hff;
            cyc(4);
            measure();
            check("group gated ch0", 16'(cnt[0]), 16'd64);
            check("group gated ch1", 16'(cnt[1]), 16'd128);
        end
    endtask

    // Reset mid-run with the bus idle; channel 0 at full duty is then gated on for exactly
    // one group step, less the PWM slots at count 255 that fall inside that step.
    task automatic t_group_rate;
        int s;
        int n;
        for (int b = 0; b < 2; b++) begin
            s = (b == 0) ? lpgd_pkg::GRP_DIM_STEP_CYC : 2 * lpgd_pkg::BLINK_STEP_CYC;
            ch_mode = 32'h0000_0003;
            ch_duty = {120'h0, 8'hff};
            grp_blink = b[0];
            grp_period = 8'(b);
            grp_duty = 8'h01;
            srst = 1'b1;
            cyc(2);
            check("mid reset outs", {led_on[11:0], if_rst, scl_lvl, sda_lvl, 1'b0}, 16'h0006);
            check("mid reset flags", {fl_hi, fl_lo}, 16'h0000);
            srst = 1'b0;
            n = 0;
            for (int k = 0; k < s + 64; k++) begin
                cyc(1);
                n += int'(led_on[0] === 1'b1);
            end
            check("group step length", 16'(n), 16'(s - (s + 1) / 256));
        end
    endtask

    task automatic t_open;
        ch_mode = 32'h5555_5555;
        cur_ok = 16'ha5c3;
        cyc(8);
        check("fault flags on", {fl_hi, fl_lo}, 16'ha5c3);
        ch_mode = 32'haaaa_aaaa;
        cur_ok = 16'h0000;
        cyc(8);
        check("fault flags pwm", {fl_hi, fl_lo}, 16'ha5c3);
        ch_mode = 32'h0000_0000;
        cyc(8);
        check("fault flags off", {fl_hi, fl_lo}, 16'h0000);
    endtask

    task automatic t_bus;
        for (int ln = 0; ln < 2; ln++) begin
            to_en = 1'b0;
            low_seen = 2'b00;
            rst_pulses = 0;
            HOST.pulse(ln, 1);
            cyc(20);
            check("spike ignored", {14'h0, low_seen}, 16'h0000);
            HOST.pulse(ln, 40);
            cyc(20);
            check("long low seen", {14'h0, low_seen}, 16'(2 ** ln));
            check("time-out defeated", 16'(rst_pulses), 16'd0);
            to_en = 1'b1;
            cyc(4);
            HOST.pulse(ln, TO_CYC / 2);
            cyc(20);
            check("short low no time-out", 16'(rst_pulses), 16'd0);
            HOST.pulse(ln, 2 * TO_CYC);
            cyc(20);
            check("time-out pulse", 16'(rst_pulses), 16'd1);
            check("lines back high", {14'h0, scl_lvl, sda_lvl}, 16'h0003);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end

    initial begin
        t_reset();
        t_pwm();
        t_group();
        t_group_rate();
        t_open();
        t_bus();
        final_report();
    end
endmodule // tb
